// [rtl/timer0_async_pkg.sv]
package timer0_async_pkg;

   // I/O space offsets; data space adds the data offset
   localparam logic [6:0] DATA_SPACE_OFFSET = 7'h20;
   localparam logic [5:0] SPECIAL_FUNCTION_TIMER_CTRL_ADDR = 6'h20;
   localparam logic [5:0] ASYNC_STATUS_ADDR = 6'h30;
   localparam logic [5:0] COMPARE_VALUE_ADDR = 6'h31;
   localparam logic [5:0] COUNT_VALUE_ADDR = 6'h32;
   localparam logic [5:0] TIMER_CONTROL_ADDR = 6'h33;
   localparam logic [5:0] TIMER_INTERRUPT_FLAGS_ADDR = 6'h36;
   localparam logic [5:0] TIMER_INTERRUPT_MASK_ADDR = 6'h37;

   // Field positions
   localparam int ASYNC_CLOCK_SELECT_BIT = 3;
   localparam int COUNT_UPDATE_BUSY_BIT = 2;
   localparam int COMPARE_UPDATE_BUSY_BIT = 1;
   localparam int CONTROL_UPDATE_BUSY_BIT = 0;
   localparam int COMPARE_BIT = 1;
   localparam int OVERFLOW_BIT = 0;
   localparam int SYNC_HOLD_MODE_BIT = 7;
   localparam int PRESCALER_RESET_A_BIT = 1;
   localparam int PRESCALER_RESET_SHARED_BIT = 0;
   localparam int CTRL_WGM0_BIT = 6;
   localparam int CTRL_WGM1_BIT = 3;

   // Reset value and count limits
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;

   // Transfer channels into the oscillator domain
   localparam int NUM_CHAN = 3;
   localparam int CHAN_COUNT = 0;
   localparam int CHAN_COMPARE = 1;
   localparam int CHAN_CONTROL = 2;

endpackage : timer0_async_pkg

// [rtl/timer0_async_register_interface.sv]
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Compare value compared with counter continuously
// - Async select picks I/O or oscillator clock
// - Select change may corrupt timer registers
// - Counter write sets busy until loaded
// - Compare write sets busy until transferred
// - Control write sets busy until loaded
// - Counter reads live; compare and control read temporaries
// - Compare irq needs enable, global, flag
// - Overflow irq needs enable, global, flag
// - Compare flag set on match, cleared
// - Overflow flag set on overflow, cleared
// - PWM overflow flag set at bottom
// - Sync hold mode keeps prescaler resets
// - Clearing sync mode clears prescaler resets
// - Prescaler reset bit self clears
// - Prescaler reset reads zero when synchronous
// - Async prescaler reset held until done
// - I/O address plus data space offset
// - Counter write blocks next compare match
module timer0_async_register_interface
   import timer0_async_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Register port
   input wire logic [6:0] addr_in,
   input wire logic data_space_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [7:0] wr_data_in,
   output logic [7:0] rd_data_out,
   // Interrupt side
   input wire logic global_irq_enable_in,
   input wire logic compare_vector_ack_in,
   input wire logic overflow_vector_ack_in,
   output logic compare_irq_out,
   output logic overflow_irq_out,
   // Oscillator tick, sampled in clk_in domain
   input wire logic osc_input_pin_in,
   // Timer outputs
   output logic wave_out_pin_out,
   output logic prescaler_reset_a_out,
   output logic prescaler_reset_shared_out
);

   logic [5:0] io_addr;
   logic hit;
   logic [7:0] count_reg, count_next;
   logic [7:0] compare_tmp_reg, compare_tmp_next;
   logic [7:0] compare_reg, compare_next;
   logic [7:0] control_tmp_reg, control_tmp_next;
   logic [7:0] control_reg, control_next;
   logic [7:0] count_tmp_reg, count_tmp_next;
   logic async_reg, async_next;
   logic [1:0] irq_mask_reg, irq_mask_next;
   logic compare_flag_reg, compare_flag_next;
   logic overflow_flag_reg, overflow_flag_next;
   logic sync_hold_mode_reg, sync_hold_mode_next;
   logic psr_a_reg, psr_a_next;
   logic psr_shared_reg, psr_shared_next;
   logic down_reg, down_next;
   logic block_match_reg, block_match_next;
   logic wave_reg, wave_next;
   logic osc_d1_reg, osc_d2_reg, osc_d3_reg;
   logic tick;
   logic psr_done_reg, psr_done_next;
   logic [NUM_CHAN-1:0] busy_reg, busy_next;
   logic [NUM_CHAN-1:0] req_reg, req_next;
   logic [NUM_CHAN-1:0] req_s1_reg, req_s2_reg;
   logic [NUM_CHAN-1:0] ack_s1_reg, ack_s2_reg;
   logic [NUM_CHAN-1:0] apply;
   logic wr_count, wr_compare, wr_control;
   logic pwm_mode, match;
   logic compare_set, overflow_set;

   // Both address spaces map to one register set
   assign io_addr = data_space_in ? 6'(addr_in - DATA_SPACE_OFFSET) : addr_in[5:0];
   assign hit = data_space_in ? (addr_in >= DATA_SPACE_OFFSET) : !addr_in[6];
   assign wr_count = wr_en_in && hit && io_addr == COUNT_VALUE_ADDR;
   assign wr_compare = wr_en_in && hit && io_addr == COMPARE_VALUE_ADDR;
   assign wr_control = wr_en_in && hit && io_addr == TIMER_CONTROL_ADDR;

   // Oscillator edge detected after two-stage synchroniser
   assign tick = async_reg ? (osc_d2_reg && !osc_d3_reg) : 1'b1;
   assign pwm_mode = control_reg[CTRL_WGM0_BIT];
   assign match = (count_reg == compare_reg) && !block_match_reg;
   assign compare_set = tick && !psr_a_reg && match;
   assign overflow_set = tick && !psr_a_reg && (pwm_mode ? (down_reg && count_reg == COUNT_BOTTOM)
      : (count_reg == COUNT_MAX));

   // Per-channel request/ack toggle handshake toward the oscillator side
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHAN; gi++)
      begin : g_chan
         // Request toggles cross in two stages; tick gates the load
         assign apply[gi] = (req_s2_reg[gi] != ack_s2_reg[gi]) && tick;
      end
   endgenerate

   always_comb
   begin
      count_next = count_reg;
      count_tmp_next = count_tmp_reg;
      compare_tmp_next = compare_tmp_reg;
      compare_next = compare_reg;
      control_tmp_next = control_tmp_reg;
      control_next = control_reg;
      async_next = async_reg;
      irq_mask_next = irq_mask_reg;
      compare_flag_next = compare_flag_reg;
      overflow_flag_next = overflow_flag_reg;
      sync_hold_mode_next = sync_hold_mode_reg;
      psr_a_next = psr_a_reg;
      psr_shared_next = psr_shared_reg;
      down_next = down_reg;
      block_match_next = block_match_reg;
      wave_next = wave_reg;
      busy_next = busy_reg;
      req_next = req_reg;
      psr_done_next = 1'b0;
      // Counter advances on each timer tick while prescaler reset A is clear; no prescaling modelled
      if (tick && !psr_a_reg)
      begin
         block_match_next = 1'b0;
         if (match)
         begin
            compare_flag_next = 1'b1;
            wave_next = !wave_reg;
         end
         if (pwm_mode)
         begin
            if (!down_reg && count_reg == COUNT_MAX)
            begin
               down_next = 1'b1;
               count_next = count_reg - 8'h01;
            end
            else if (down_reg && count_reg == COUNT_BOTTOM)
            begin
               down_next = 1'b0;
               overflow_flag_next = 1'b1;
               count_next = count_reg + 8'h01;
            end
            else
               count_next = down_reg ? count_reg - 8'h01 : count_reg + 8'h01;
         end
         else
         begin
            if (count_reg == COUNT_MAX)
               overflow_flag_next = 1'b1;
            count_next = count_reg + 8'h01;
         end
      end
      // Prescaler reset completes on an oscillator tick when async
      if (psr_a_reg && tick)
         psr_done_next = 1'b1;
      if (psr_done_reg && !sync_hold_mode_reg)
         psr_a_next = 1'b0;
      // Oscillator-side loads from temporaries, acked via handshake
      if (apply[CHAN_COUNT])
      begin
         count_next = count_tmp_reg;
         block_match_next = 1'b1;
      end
      if (apply[CHAN_COMPARE])
         compare_next = compare_tmp_reg;
      if (apply[CHAN_CONTROL])
         control_next = control_tmp_reg;
      for (int i = 0; i < NUM_CHAN; i++)
         if (busy_reg[i] && req_reg[i] == ack_s2_reg[i] && !apply[i])
            busy_next[i] = 1'b0;
      // Vector acknowledges clear flags; a same-cycle set wins
      if (compare_vector_ack_in && !compare_set)
         compare_flag_next = 1'b0;
      if (overflow_vector_ack_in && !overflow_set)
         overflow_flag_next = 1'b0;
      if (wr_en_in && hit)
      begin
         unique case (io_addr)
            COUNT_VALUE_ADDR:
               if (async_reg)
               begin
                  // Writing while busy may corrupt; software must wait
                  count_tmp_next = wr_data_in;
                  busy_next[CHAN_COUNT] = 1'b1;
                  req_next[CHAN_COUNT] = !req_reg[CHAN_COUNT];
               end
               else
               begin
                  count_next = wr_data_in; // CPU write has priority
                  block_match_next = 1'b1;
               end
            COMPARE_VALUE_ADDR:
            begin
               compare_tmp_next = wr_data_in;
               if (async_reg)
               begin
                  busy_next[CHAN_COMPARE] = 1'b1;
                  req_next[CHAN_COMPARE] = !req_reg[CHAN_COMPARE];
               end
               else
                  compare_next = wr_data_in;
            end
            TIMER_CONTROL_ADDR:
            begin
               control_tmp_next = wr_data_in;
               if (async_reg)
               begin
                  busy_next[CHAN_CONTROL] = 1'b1;
                  req_next[CHAN_CONTROL] = !req_reg[CHAN_CONTROL];
               end
               else
                  control_next = wr_data_in;
            end
            ASYNC_STATUS_ADDR:
               // Switching source leaves timer values unreliable
               async_next = wr_data_in[ASYNC_CLOCK_SELECT_BIT];
            TIMER_INTERRUPT_MASK_ADDR:
               irq_mask_next = wr_data_in[1:0];
            TIMER_INTERRUPT_FLAGS_ADDR:
            begin
               if (wr_data_in[COMPARE_BIT] && !compare_set)
                  compare_flag_next = 1'b0;
               if (wr_data_in[OVERFLOW_BIT] && !overflow_set)
                  overflow_flag_next = 1'b0;
            end
            SPECIAL_FUNCTION_TIMER_CTRL_ADDR:
            begin
               sync_hold_mode_next = wr_data_in[SYNC_HOLD_MODE_BIT];
               if (!wr_data_in[SYNC_HOLD_MODE_BIT])
               begin
                  // Release first, so a reset written with the mode bit clear still acts
                  psr_a_next = 1'b0;
                  psr_shared_next = 1'b0;
               end
               if (wr_data_in[PRESCALER_RESET_A_BIT])
                  psr_a_next = 1'b1;
               if (wr_data_in[PRESCALER_RESET_SHARED_BIT])
                  psr_shared_next = 1'b1;
            end
            default:
            begin
            end
         endcase
      end
      // Shared reset self-clears unless held by sync mode
      if (psr_shared_reg && !sync_hold_mode_reg && !(wr_en_in && hit
          && io_addr == SPECIAL_FUNCTION_TIMER_CTRL_ADDR))
         psr_shared_next = 1'b0;
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         count_reg <= REG_RESET;
         count_tmp_reg <= REG_RESET;
         compare_tmp_reg <= REG_RESET;
         compare_reg <= REG_RESET;
         control_tmp_reg <= REG_RESET;
         control_reg <= REG_RESET;
         async_reg <= 1'b0;
         irq_mask_reg <= 2'h0;
         compare_flag_reg <= 1'b0;
         overflow_flag_reg <= 1'b0;
         sync_hold_mode_reg <= 1'b0;
         psr_a_reg <= 1'b0;
         psr_shared_reg <= 1'b0;
         down_reg <= 1'b0;
         block_match_reg <= 1'b1; // Count has not moved yet, so no match on the first tick
         wave_reg <= 1'b0;
         psr_done_reg <= 1'b0;
         busy_reg <= '0;
         req_reg <= '0;
         req_s1_reg <= '0;
         req_s2_reg <= '0;
         ack_s1_reg <= '0;
         ack_s2_reg <= '0;
         osc_d1_reg <= 1'b0;
         osc_d2_reg <= 1'b0;
         osc_d3_reg <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         count_tmp_reg <= count_tmp_next;
         compare_tmp_reg <= compare_tmp_next;
         compare_reg <= compare_next;
         control_tmp_reg <= control_tmp_next;
         control_reg <= control_next;
         async_reg <= async_next;
         irq_mask_reg <= irq_mask_next;
         compare_flag_reg <= compare_flag_next;
         overflow_flag_reg <= overflow_flag_next;
         sync_hold_mode_reg <= sync_hold_mode_next;
         psr_a_reg <= psr_a_next;
         psr_shared_reg <= psr_shared_next;
         down_reg <= down_next;
         block_match_reg <= block_match_next;
         wave_reg <= wave_next;
         psr_done_reg <= psr_done_next;
         busy_reg <= busy_next;
         req_reg <= req_next;
         req_s1_reg <= req_reg;
         req_s2_reg <= req_s1_reg;
         ack_s1_reg <= req_s2_reg & apply | ack_s2_reg & ~apply;
         ack_s2_reg <= ack_s1_reg;
         osc_d1_reg <= osc_input_pin_in;
         osc_d2_reg <= osc_d1_reg;
         osc_d3_reg <= osc_d2_reg;
      end
   end

   // Read mux: counter live, compare and control from temporaries
   always_comb
   begin
      rd_data_out = 8'h00;
      if (rd_en_in && hit)
      begin
         unique case (io_addr)
            COUNT_VALUE_ADDR: rd_data_out = count_reg;
            COMPARE_VALUE_ADDR: rd_data_out = compare_tmp_reg;
            TIMER_CONTROL_ADDR: rd_data_out = control_tmp_reg;
            ASYNC_STATUS_ADDR: rd_data_out = {4'h0, async_reg, busy_reg[CHAN_COUNT],
               busy_reg[CHAN_COMPARE], busy_reg[CHAN_CONTROL]};
            TIMER_INTERRUPT_MASK_ADDR: rd_data_out = {6'h00, irq_mask_reg};
            TIMER_INTERRUPT_FLAGS_ADDR: rd_data_out = {6'h00, compare_flag_reg,
               overflow_flag_reg};
            // Reset bit reads zero when on the CPU clock
            SPECIAL_FUNCTION_TIMER_CTRL_ADDR: rd_data_out = {sync_hold_mode_reg, 5'h00,
               psr_a_reg && async_reg, psr_shared_reg};
            default: rd_data_out = 8'h00;
         endcase
      end
   end

   assign compare_irq_out = irq_mask_reg[COMPARE_BIT] && global_irq_enable_in
      && compare_flag_reg;
   assign overflow_irq_out = irq_mask_reg[OVERFLOW_BIT] && global_irq_enable_in
      && overflow_flag_reg;
   assign wave_out_pin_out = wave_reg;
   assign prescaler_reset_a_out = psr_a_reg;
   assign prescaler_reset_shared_out = psr_shared_reg;

endmodule : timer0_async_register_interface

`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
   import timer0_async_pkg::*;
;
   logic clk_in = 1'b0, rst_b_in = 1'b0, data_space_in = 1'b0, wr_en_in = 1'b0, rd_en_in = 1'b0;
   logic global_irq_enable_in = 1'b0, compare_vector_ack_in = 1'b0, overflow_vector_ack_in = 1'b0;
   logic osc_input_pin_in = 1'b0, osc_run = 1'b0;
   logic [6:0] addr_in = 7'h00;
   logic [7:0] wr_data_in = 8'h00, rd_data_out;
   logic compare_irq_out, overflow_irq_out, wave_out_pin_out;
   logic prescaler_reset_a_out, prescaler_reset_shared_out;
   int err_count = 0, total_checks = 0;
   logic [5:0] reset_addr [5] = '{SPECIAL_FUNCTION_TIMER_CTRL_ADDR, ASYNC_STATUS_ADDR,
      COMPARE_VALUE_ADDR, TIMER_INTERRUPT_FLAGS_ADDR, TIMER_INTERRUPT_MASK_ADDR};
   logic [5:0] busy_addr [3] = '{COUNT_VALUE_ADDR, COMPARE_VALUE_ADDR, TIMER_CONTROL_ADDR};
   int busy_bit [3] = '{COUNT_UPDATE_BUSY_BIT, COMPARE_UPDATE_BUSY_BIT, CONTROL_UPDATE_BUSY_BIT};
   logic [7:0] busy_val [3] = '{8'h10, 8'h33, 8'h00};
   always #4 clk_in = ~clk_in;
   // Oscillator edges land on falling edges of clk_in and only run while asked
   always #32 if (osc_run) osc_input_pin_in = ~osc_input_pin_in;
   timer0_async_register_interface dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
      .data_space_in(data_space_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
      .global_irq_enable_in(global_irq_enable_in), .compare_vector_ack_in(compare_vector_ack_in),
      .overflow_vector_ack_in(overflow_vector_ack_in), .compare_irq_out(compare_irq_out),
      .overflow_irq_out(overflow_irq_out), .osc_input_pin_in(osc_input_pin_in),
      .wave_out_pin_out(wave_out_pin_out), .prescaler_reset_a_out(prescaler_reset_a_out),
      .prescaler_reset_shared_out(prescaler_reset_shared_out));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Strobes stay up between like calls, so no signal is assigned twice in one step
   task automatic wr(input logic [5:0] a, input logic ds, input logic [7:0] d);
      rd_en_in = 1'b0;
      addr_in = {1'b0, a} + (ds ? DATA_SPACE_OFFSET : 7'h00);
      data_space_in = ds;
      wr_data_in = d;
      wr_en_in = 1'b1;
      @(negedge clk_in);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic ds, input logic [7:0] exp);
      wr_en_in = 1'b0;
      addr_in = {1'b0, a} + (ds ? DATA_SPACE_OFFSET : 7'h00);
      data_space_in = ds;
      rd_en_in = 1'b1;
      #2;
      check(rd_data_out, exp);
      @(negedge clk_in);
   endtask : rd
   task automatic idle(input int n);
      wr_en_in = 1'b0;
      rd_en_in = 1'b0;
      repeat (n) @(negedge clk_in);
   endtask : idle
   // Bounded wait for a busy bit; a stuck bit shows in the read that follows
   task automatic poll(input int b);
      wr_en_in = 1'b0;
      addr_in = {1'b0, ASYNC_STATUS_ADDR};
      data_space_in = 1'b0;
      rd_en_in = 1'b1;
      for (int i = 0; i < 100; i++)
      begin
         #2;
         if (rd_data_out[b] === 1'b0) i = 100;
         @(negedge clk_in);
      end
   endtask : poll
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   initial
   begin
      #100000;
      err_count++;
      print_verdict();
   end
   initial
   begin
      repeat (4) @(negedge clk_in);
      rst_b_in = 1'b1;
      foreach (reset_addr[i])
      begin
         rd(reset_addr[i], 1'b0, 8'h00);
         rd(reset_addr[i], 1'b1, 8'h00);
      end
      rd(6'h3f, 1'b0, 8'h00);
      wr(COMPARE_VALUE_ADDR, 1'b1, 8'h5a);
      rd(COMPARE_VALUE_ADDR, 1'b0, 8'h5a);
      wr(TIMER_INTERRUPT_MASK_ADDR, 1'b0, 8'hff);
      rd(TIMER_INTERRUPT_MASK_ADDR, 1'b1, 8'h03);
      wr(SPECIAL_FUNCTION_TIMER_CTRL_ADDR, 1'b0, 8'h02);
      rd(SPECIAL_FUNCTION_TIMER_CTRL_ADDR, 1'b0, 8'h00);
      wr(COMPARE_VALUE_ADDR, 1'b0, 8'h80);
      wr(COUNT_VALUE_ADDR, 1'b0, 8'h00);
      idle(300);
      global_irq_enable_in = 1'b1;
      rd(TIMER_INTERRUPT_FLAGS_ADDR, 1'b0, 8'h03);
      check({7'h00, compare_irq_out}, 8'h01);
      check({7'h00, overflow_irq_out}, 8'h01);
      check({7'h00, wave_out_pin_out}, 8'h01);
      global_irq_enable_in = 1'b0;
      #1;
      check({6'h00, compare_irq_out, overflow_irq_out}, 8'h00);
      @(negedge clk_in);
      wr(COUNT_VALUE_ADDR, 1'b0, 8'h00);
      wr(TIMER_INTERRUPT_FLAGS_ADDR, 1'b0, 8'h03);
      rd(TIMER_INTERRUPT_FLAGS_ADDR, 1'b0, 8'h00);
      idle(300);
      for (int k = 0; k < 2; k++)
      begin
         compare_vector_ack_in = (k == 0);
         overflow_vector_ack_in = (k == 1);
         @(negedge clk_in);
         compare_vector_ack_in = 1'b0;
         overflow_vector_ack_in = 1'b0;
         rd(TIMER_INTERRUPT_FLAGS_ADDR, 1'b0, (k == 0) ? 8'h01 : 8'h00);
      end
      // Count written onto the compare value: the match on the next tick is dropped
      wr(COUNT_VALUE_ADDR, 1'b0, 8'h80);
      idle(2);
      rd(TIMER_INTERRUPT_FLAGS_ADDR, 1'b0, 8'h00);
      // Up/down mode: no overflow at the top, overflow when turning at zero
      wr(TIMER_CONTROL_ADDR, 1'b0, 8'h40);
      wr(COUNT_VALUE_ADDR, 1'b0, 8'hf0);
      wr(TIMER_INTERRUPT_FLAGS_ADDR, 1'b0, 8'h03);
      idle(30);
      rd(TIMER_INTERRUPT_FLAGS_ADDR, 1'b0, 8'h00);
      idle(260);
      rd(TIMER_INTERRUPT_FLAGS_ADDR, 1'b0, 8'h03);
      check({7'h00, wave_out_pin_out}, 8'h01);
      wr(ASYNC_STATUS_ADDR, 1'b0, 8'h08);
      osc_run = 1'b1;
      rd(ASYNC_STATUS_ADDR, 1'b0, 8'h08);
      for (int k = 0; k < 3; k++)
      begin
         wr(busy_addr[k], 1'b0, busy_val[k]);
         rd(ASYNC_STATUS_ADDR, 1'b0, 8'h08 | (8'h01 << busy_bit[k]));
         poll(busy_bit[k]);
         rd(ASYNC_STATUS_ADDR, 1'b0, 8'h08);
      end
      rd(COMPARE_VALUE_ADDR, 1'b0, 8'h33);
      wr(SPECIAL_FUNCTION_TIMER_CTRL_ADDR, 1'b0, 8'h83);
      idle(100);
      rd(SPECIAL_FUNCTION_TIMER_CTRL_ADDR, 1'b0, 8'h83);
      check({6'h00, prescaler_reset_a_out, prescaler_reset_shared_out}, 8'h03);
      wr(SPECIAL_FUNCTION_TIMER_CTRL_ADDR, 1'b0, 8'h00);
      idle(100);
      rd(SPECIAL_FUNCTION_TIMER_CTRL_ADDR, 1'b0, 8'h00);
      check({6'h00, prescaler_reset_a_out, prescaler_reset_shared_out}, 8'h00);
      wr(SPECIAL_FUNCTION_TIMER_CTRL_ADDR, 1'b0, 8'h02);
      rd(SPECIAL_FUNCTION_TIMER_CTRL_ADDR, 1'b0, 8'h02);
      idle(100);
      rd(SPECIAL_FUNCTION_TIMER_CTRL_ADDR, 1'b0, 8'h00);
      osc_run = 1'b0;
      print_verdict();
   end
endmodule : tb
`default_nettype wire

// [verif/timer0_async_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module timer0_async_checker
   import timer0_async_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Register port
   input wire logic [6:0] addr_in,
   input wire logic data_space_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [7:0] wr_data_in,
   input wire logic [7:0] rd_data_out,
   // Interrupt and prescaler side
   input wire logic global_irq_enable_in,
   input wire logic compare_irq_out,
   input wire logic overflow_irq_out,
   input wire logic prescaler_reset_a_out,
   input wire logic prescaler_reset_shared_out
);
   function automatic logic hit(input logic [6:0] ad, input logic ds, input logic [5:0] a);
      return ad == ({1'b0, a} + (ds ? DATA_SPACE_OFFSET : 7'h00));
   endfunction : hit
   logic hit_cmp, hit_async, hit_mask, hit_sfr, hit_none;
   logic async_reg, async_next, hold_reg, hold_next;
   assign hit_cmp = hit(addr_in, data_space_in, COMPARE_VALUE_ADDR);
   assign hit_async = hit(addr_in, data_space_in, ASYNC_STATUS_ADDR);
   assign hit_mask = hit(addr_in, data_space_in, TIMER_INTERRUPT_MASK_ADDR);
   assign hit_sfr = hit(addr_in, data_space_in, SPECIAL_FUNCTION_TIMER_CTRL_ADDR);
   assign hit_none = hit(addr_in, data_space_in, 6'h3f);
   // Shadow of the mode bits, so checks know which clocking is active
   always_comb
   begin
      async_next = (wr_en_in && hit_async) ? wr_data_in[ASYNC_CLOCK_SELECT_BIT] : async_reg;
      hold_next = (wr_en_in && hit_sfr) ? wr_data_in[SYNC_HOLD_MODE_BIT] : hold_reg;
   end
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         async_reg <= 1'b0;
         hold_reg <= 1'b0;
      end
      else
      begin
         async_reg <= async_next;
         hold_reg <= hold_next;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_wr_cmp; wr_en_in && hit_cmp; endsequence
   sequence s_rd_async; rd_en_in && hit_async; endsequence
   AST_CMP_IRQ_GATE: assert property (!global_irq_enable_in |-> !compare_irq_out)
      else $error("compare irq without global enable");
   AST_OVF_IRQ_GATE: assert property (!global_irq_enable_in |-> !overflow_irq_out)
      else $error("overflow irq without global enable");
   AST_IDLE_READ: assert property (!rd_en_in |-> rd_data_out == 8'h00)
      else $error("read data not zero while idle");
   AST_UNMAPPED_READ: assert property (rd_en_in && hit_none |-> rd_data_out == 8'h00)
      else $error("unmapped read not zero");
   AST_CMP_READBACK: assert property (s_wr_cmp ##1 (rd_en_in && hit_cmp)
      |-> rd_data_out == $past(wr_data_in)) else $error("compare readback wrong");
   AST_MASK_READBACK: assert property (wr_en_in && hit_mask ##1 rd_en_in && hit_mask
      |-> rd_data_out == ($past(wr_data_in) & 8'h03)) else $error("mask readback wrong");
   AST_CMP_BUSY: assert property ((async_reg && wr_en_in && hit_cmp) ##1 s_rd_async
      |-> rd_data_out[COMPARE_UPDATE_BUSY_BIT]) else $error("compare busy not set");
   AST_SYNC_PSR_READ: assert property (!async_reg && rd_en_in && hit_sfr
      |-> !rd_data_out[PRESCALER_RESET_A_BIT]) else $error("prescaler reset reads one");
   AST_HOLD_KEEP: assert property (hold_reg && prescaler_reset_a_out
      && !(wr_en_in && hit_sfr) |=> prescaler_reset_a_out) else $error("held reset dropped");
   AST_HOLD_RELEASE: assert property (hold_reg && wr_en_in && hit_sfr && wr_data_in == 8'h00
      |-> ##[1:40] !prescaler_reset_a_out && !prescaler_reset_shared_out)
      else $error("prescaler resets not released");
endmodule : timer0_async_checker
bind timer0_async_register_interface timer0_async_checker chk (.clk_in(clk_in),
   .rst_b_in(rst_b_in), .addr_in(addr_in), .data_space_in(data_space_in), .wr_en_in(wr_en_in),
   .rd_en_in(rd_en_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
   .global_irq_enable_in(global_irq_enable_in), .compare_irq_out(compare_irq_out),
   .overflow_irq_out(overflow_irq_out), .prescaler_reset_a_out(prescaler_reset_a_out),
   .prescaler_reset_shared_out(prescaler_reset_shared_out));
`default_nettype wire
